// >>> ebsc_pkg.sv
// Package for the energy buffer state controller.
// Assumes a 250 MHz core clock and register access through a byte port.
package ebsc_pkg;

	localparam int CLK_MHZ = 250;

	// Timing figures in their own units
	localparam int STARTUP_MS      = 20;
	localparam int LOWBAT_US       = 16;
	localparam int WARN_PULSE_US   = 100;
	localparam int CONV_FREQ_MHZ   = 1;

	localparam int STARTUP_CYCLES  = STARTUP_MS * 1000 * CLK_MHZ;
	localparam int LOWBAT_CYCLES   = LOWBAT_US * CLK_MHZ;
	localparam int WARN_CYCLES     = WARN_PULSE_US * CLK_MHZ;
	localparam int CONV_CYCLES     = CLK_MHZ / CONV_FREQ_MHZ;

	// Register offsets
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_VCAP    = 8'h05;
	localparam logic [7:0] ADDR_PROFILE = 8'h07;
	localparam logic [7:0] ADDR_CMD     = 8'h08;
	localparam logic [7:0] ADDR_WARN    = 8'h09;
	localparam logic [7:0] ADDR_CHARGE  = 8'h10;
	localparam logic [7:0] ADDR_FIX     = 8'h11;
	localparam logic [7:0] ADDR_CEIL    = 8'h12;

	// Field positions
	localparam int ST_READY   = 0;
	localparam int ST_LOWBAT  = 1;
	localparam int ST_ALARM   = 5;
	localparam int ST_WARNING = 6;
	localparam int CMD_DEMAND = 0;
	localparam int CMD_CONT   = 1;
	localparam int CMD_ACT    = 2;
	localparam int CMD_AUTO   = 3;
	localparam int WARN_EN    = 7;
	localparam int CHG_HIZ    = 4;
	localparam int CEIL_SEL   = 4;

	// Reset values
	localparam logic [7:0] CHARGE_RST  = 8'h00;
	localparam logic [7:0] CEIL_RST    = 8'h10;
	localparam logic [7:0] CMD_RST     = 8'h00;
	localparam logic [7:0] WARN_RST    = 8'h04;
	localparam logic [7:0] FIX_RST     = 8'h08;
	localparam logic [5:0] PROF_RST    = 6'h01;

	// Charge current code, then level codes in capacitor readback units
	localparam logic [2:0] ICH_EMERGENCY = 3'h4;
	localparam logic [4:0] CEIL_LOW      = 5'h10;
	localparam logic [4:0] CEIL_HIGH     = 5'h1f;
	localparam logic [4:0] FIX_BASE      = 5'h08;
	localparam logic [4:0] LEVEL_EMPTY   = 5'h00;

	typedef enum logic [1:0] {
		ST_STARTUP = 2'b00,
		ST_STANDBY = 2'b01,
		ST_CHARGE  = 2'b10,
		ST_ACTIVE  = 2'b11
	} ebsc_state_t;

	typedef enum logic [1:0] {
		PH_OFF          = 2'b00,
		PH_CHARGE_BOOST = 2'b01,
		PH_ACTIVE_BUCK  = 2'b10,
		PH_ACTIVE_BOOST = 2'b11
	} ebsc_phase_t;

endpackage

// >>> ebsc_timer.sv
// Counts cycles while run is high and flags when the count is reached.
// Assumes run drops to restart the count.
module ebsc_timer
	import ebsc_pkg::*;
#(
	parameter int COUNT = 16
)
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic run,
	output logic      done
);
	logic [31:0] cnt_r;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_r <= 32'h0;
		else if (!run)
			cnt_r <= 32'h0;
		else if (cnt_r < 32'(COUNT))
			cnt_r <= cnt_r + 32'h1;
	end

	assign done = run && (cnt_r >= 32'(COUNT));
endmodule

// >>> ebsc_phase.sv
// Converter switch phase generator at a fixed 1 MHz period.
// Assumes the mode input is stable over many periods.
module ebsc_phase
	import ebsc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire ebsc_phase_t mode,
	output logic             swPre,
	output logic             sw1,
	output logic             sw2,
	output logic             sw3,
	output logic             sw4
);
	logic [7:0] cnt_r;
	logic       primary;

	// Fixed frequency period counter
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_r <= 8'h00;
		else if (cnt_r == 8'(CONV_CYCLES - 1))
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end // RULE20

	assign primary = cnt_r < 8'(CONV_CYCLES / 2);

	// Switch pairs per phase
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			swPre <= 1'b0;
			sw1   <= 1'b0;
			sw2   <= 1'b0;
			sw3   <= 1'b0;
			sw4   <= 1'b0;
		end
		else
		begin
			unique case (mode)
				PH_OFF:
				begin
					swPre <= 1'b0;
					sw1   <= 1'b0;
					sw2   <= 1'b0;
					sw3   <= 1'b0;
					sw4   <= 1'b0;
				end
				PH_CHARGE_BOOST:
				begin
					swPre <= primary; // RULE22
					sw1   <= 1'b0;
					sw2   <= !primary;
					sw3   <= primary;
					sw4   <= !primary;
				end
				PH_ACTIVE_BUCK:
				begin
					swPre <= 1'b0; // RULE22
					sw1   <= primary;
					sw2   <= 1'b0;
					sw3   <= !primary;
					sw4   <= 1'b1;
				end
				PH_ACTIVE_BOOST:
				begin
					swPre <= 1'b0; // RULE22
					sw1   <= !primary;
					sw2   <= primary;
					sw3   <= 1'b0;
					sw4   <= 1'b1;
				end
			endcase
		end
	end
endmodule

// >>> ebsc_state_control.sv
// Operating state controller: sequencing, alarms, ready pin, converter mode.
// Assumes a serial front end that presents one byte register access per
// cycle, and analog comparators already synchronous to clk.

// Summary of operation
// RULE1 - Startup lasts 20 ms, then Standby
// RULE2 - Host waits 20 ms before serial access
// RULE3 - Standby accepts register writes
// RULE4 - Settings kept while supply uninterrupted
// RULE5 - Standby holds ready pin and bit low
// RULE6 - Demand, continuous or auto start enter Charge
// RULE7 - Charge current from field charge_and_battery_settings[7:5]
// RULE8 - Codes 0-3 normal, 4 emergency
// RULE9 - Pause charging while battery below minimum
// RULE10 - Low battery over 16 us sets flag
// RULE11 - Target from fixed field or optimizer
// RULE12 - Never charge above selected ceiling
// RULE13 - Capacitor level readable at 0x05[4:0]
// RULE14 - On-demand enters Active at end-of-charge
// RULE15 - Continuous stays charging and tops up
// RULE16 - Force active; clearing demand returns Standby
// RULE17 - Continuous activate toggles Active and Charge
// RULE18 - Enabled warning flags and pulses ready low
// RULE19 - Output alarm holds ready low until Charge
// RULE20 - Converter switches at fixed 1 MHz
// RULE21 - Precharge below 1.6 V, boost above
// RULE22 - Switch pairs per converter phase
// RULE23 - Ready bit mirrors ready pin
// RULE24 - High-impedance bit floats switched output
// RULE25 - Reset enters Startup, clears mode bits
module ebsc_state_control
	import ebsc_pkg::*;
#(
	parameter int STARTUP_COUNT = STARTUP_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	input  wire logic       startPin,
	input  wire logic [4:0] capLevel,
	input  wire logic       capAbovePrecharge,
	input  wire logic       batteryLow,
	input  wire logic       outputLow,
	input  wire logic       capBelowOutput,
	input  wire logic [4:0] optTarget,
	output logic            readyPin,
	output logic      [2:0] chargeCurrentCode,
	output logic            emergencyCharge,
	output logic      [2:0] batteryMinCode,
	output logic      [3:0] outputVoltageCode,
	output logic            chargeRun,
	output logic            switchedOutputHiZ,
	output logic            switchedOutputToBattery,
	output logic            alwaysOnFromBattery,
	output ebsc_state_t     stateOut,
	output logic            prechargeSwitch,
	output logic            sw1,
	output logic            sw2,
	output logic            sw3,
	output logic            sw4
);
	ebsc_state_t state_r;
	ebsc_state_t state_nxt;
	ebsc_phase_t phaseMode;

	logic [7:0] cmd_r;
	logic [7:0] chargeCfg_r;
	logic [7:0] ceilCfg_r;
	logic [7:0] warnCfg_r;
	logic [7:0] fixCfg_r;
	logic [5:0] profile_r;
	logic [4:0] vcap_r;
	logic       lowBat_r;
	logic       alarm_r;
	logic       warning_r;
	logic       reachedOnce_r;
	logic       readyPin_r;

	logic       demandReq;
	logic       contReq;
	logic       actReq;
	logic [4:0] endLevel;
	logic       reached;
	logic       startupDone;
	logic       lowBatDone;
	logic       warnPulse;
	logic       warnSet;
	logic       enterCharge;
	logic       readyLevel;

	function automatic logic [4:0] minLevel(input logic [4:0] a,
		input logic [4:0] b);
		minLevel = (a < b) ? a : b;
	endfunction

	function automatic logic regHit(input logic [7:0] addr);
		regHit = regWrEn && (regAddr == addr) && (state_r != ST_STARTUP);
	endfunction

	assign demandReq = cmd_r[CMD_DEMAND] || (cmd_r[CMD_AUTO] && startPin);
	assign contReq   = cmd_r[CMD_CONT];
	assign actReq    = cmd_r[CMD_ACT];

	// End-of-charge level, clamped to the ceiling
	assign endLevel = minLevel((profile_r == 6'h00) ?
		(FIX_BASE + {1'b0, fixCfg_r[7:4]}) : optTarget, // RULE11
		ceilCfg_r[CEIL_SEL] ? CEIL_HIGH : CEIL_LOW); // RULE12
	assign reached  = capLevel >= endLevel;

	ebsc_timer #(.COUNT(STARTUP_COUNT)) u_startup (
		.clk  (clk),
		.rstn (rstn),
		.run  (state_r == ST_STARTUP),
		.done (startupDone)
	);

	ebsc_timer #(.COUNT(LOWBAT_CYCLES)) u_lowbat (
		.clk  (clk),
		.rstn (rstn),
		.run  ((state_r == ST_CHARGE) && batteryLow),
		.done (lowBatDone)
	); // RULE10

	assign warnSet = (state_r == ST_ACTIVE) && warnCfg_r[WARN_EN] &&
		(capLevel < {1'b0, warnCfg_r[3:0]});

	ebsc_timer #(.COUNT(WARN_CYCLES)) u_warn (
		.clk  (clk),
		.rstn (rstn),
		.run  (warning_r && (state_r == ST_ACTIVE)),
		.done (warnPulse)
	);

	// Next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_STARTUP:
				if (startupDone)
					state_nxt = ST_STANDBY; // RULE1
			ST_STANDBY:
				if (demandReq || contReq)
					state_nxt = ST_CHARGE; // RULE6
			ST_CHARGE:
				if (!demandReq && !contReq)
					state_nxt = ST_STANDBY;
				else if (actReq)
					state_nxt = ST_ACTIVE; // RULE16
				else if (!contReq && reached)
					state_nxt = ST_ACTIVE; // RULE14
			ST_ACTIVE:
				if (contReq)
				begin
					if (!actReq)
						state_nxt = ST_CHARGE; // RULE17
				end
				else if (!demandReq)
					state_nxt = ST_STANDBY; // RULE16
		endcase
	end

	assign enterCharge = (state_nxt == ST_CHARGE) && (state_r != ST_CHARGE);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_r <= ST_STARTUP; // RULE25
		else
			state_r <= state_nxt;
	end

	// Command and configuration registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmd_r       <= CMD_RST; // RULE25
			chargeCfg_r <= CHARGE_RST;
			ceilCfg_r   <= CEIL_RST;
			warnCfg_r   <= WARN_RST; // RULE18
			fixCfg_r    <= FIX_RST;
			profile_r   <= PROF_RST;
		end
		else
		begin
			// Held until overwritten
			if (regHit(ADDR_CMD))
				cmd_r <= regWrData; // RULE3 RULE4
			if (regHit(ADDR_CHARGE))
				chargeCfg_r <= regWrData; // RULE3
			if (regHit(ADDR_CEIL))
				ceilCfg_r <= regWrData; // RULE3
			if (regHit(ADDR_WARN))
				warnCfg_r <= regWrData;
			if (regHit(ADDR_FIX))
				fixCfg_r <= regWrData;
			if (regHit(ADDR_PROFILE))
				profile_r <= regWrData[5:0];
		end
	end

	// Capacitor readback, frozen in Standby
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			vcap_r <= LEVEL_EMPTY;
		else if ((state_r == ST_CHARGE) || (state_r == ST_ACTIVE))
			vcap_r <= capLevel; // RULE13
	end

	// Sticky alarms; setting wins over clearing
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lowBat_r      <= 1'b0;
			alarm_r       <= 1'b0;
			warning_r     <= 1'b0;
			reachedOnce_r <= 1'b0;
		end
		else
		begin
			if (lowBatDone)
				lowBat_r <= 1'b1; // RULE10
			else if (enterCharge && (state_r == ST_STANDBY))
				lowBat_r <= 1'b0;
			if ((state_r == ST_ACTIVE) && outputLow)
				alarm_r <= 1'b1; // RULE19
			else if (enterCharge)
				alarm_r <= 1'b0; // RULE19
			if (warnSet)
				warning_r <= 1'b1; // RULE18
			else if (enterCharge)
				warning_r <= 1'b0;
			if ((state_r == ST_CHARGE) && reached)
				reachedOnce_r <= 1'b1;
			else if (state_r == ST_STANDBY)
				reachedOnce_r <= 1'b0;
		end
	end

	// Ready pin level
	assign readyLevel = !alarm_r && (capLevel != LEVEL_EMPTY) &&
		!(warning_r && !warnPulse) && // RULE18
		((state_r == ST_ACTIVE) ||
		((state_r == ST_CHARGE) && contReq && reachedOnce_r));

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			readyPin_r <= 1'b0; // RULE25
		else if (state_nxt == ST_STANDBY)
			readyPin_r <= 1'b0; // RULE5
		else
			readyPin_r <= readyLevel; // RULE19
	end

	assign readyPin = readyPin_r;
	assign stateOut = state_r;

	// Register readback
	always_comb
	begin
		regRdData = 8'h00;
		unique case (regAddr)
			ADDR_STATUS:
			begin
				regRdData[ST_READY]   = readyPin_r; // RULE23
				regRdData[ST_LOWBAT]  = lowBat_r;
				regRdData[ST_ALARM]   = alarm_r;
				regRdData[ST_WARNING] = warning_r;
			end
			ADDR_VCAP:    regRdData = {3'h0, vcap_r};
			ADDR_PROFILE: regRdData = {2'h0, profile_r};
			ADDR_CMD:     regRdData = cmd_r;
			ADDR_WARN:    regRdData = warnCfg_r;
			ADDR_CHARGE:  regRdData = chargeCfg_r;
			ADDR_FIX:     regRdData = fixCfg_r;
			ADDR_CEIL:    regRdData = ceilCfg_r;
			default:      regRdData = 8'h00;
		endcase
	end

	// Charge control and output path
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chargeCurrentCode       <= 3'h0;
			emergencyCharge         <= 1'b0;
			batteryMinCode          <= 3'h0;
			outputVoltageCode       <= 4'h0;
			chargeRun               <= 1'b0;
			switchedOutputHiZ       <= 1'b0;
			switchedOutputToBattery <= 1'b1;
			alwaysOnFromBattery     <= 1'b1;
		end
		else
		begin
			chargeCurrentCode <= chargeCfg_r[7:5]; // RULE7
			emergencyCharge   <= chargeCfg_r[7:5] == ICH_EMERGENCY; // RULE8
			batteryMinCode    <= chargeCfg_r[2:0];
			outputVoltageCode <= warnCfg_r[3:0];
			chargeRun <= (state_r == ST_CHARGE) && !batteryLow && // RULE9
				!reached; // RULE15
			switchedOutputHiZ <= (state_r != ST_ACTIVE) &&
				chargeCfg_r[CHG_HIZ]; // RULE24
			switchedOutputToBattery <= (state_r != ST_ACTIVE) &&
				!chargeCfg_r[CHG_HIZ]; // RULE24
			alwaysOnFromBattery <= state_r != ST_ACTIVE;
		end
	end

	// Converter phase selection
	always_comb
	begin
		phaseMode = PH_OFF;
		if (chargeRun && capAbovePrecharge && (state_r == ST_CHARGE))
			phaseMode = PH_CHARGE_BOOST; // RULE21
		else if (state_r == ST_ACTIVE)
			phaseMode = capBelowOutput ? PH_ACTIVE_BOOST : PH_ACTIVE_BUCK;
	end

	logic swPreBoost;

	ebsc_phase u_phase (
		.clk   (clk),
		.rstn  (rstn),
		.mode  (phaseMode),
		.swPre (swPreBoost),
		.sw1   (sw1),
		.sw2   (sw2),
		.sw3   (sw3),
		.sw4   (sw4)
	);

	// Low-current precharge below threshold
	assign prechargeSwitch = swPreBoost ||
		(chargeRun && !capAbovePrecharge && (state_r == ST_CHARGE)); // RULE21
endmodule

// >>> ebsc_state_control_asserts.sv
// Concurrent checks on the state controller ports.
// Bound to every ebsc_state_control instance; one clock domain.
module ebsc_state_control_asserts
	import ebsc_pkg::*;
#(
	parameter int STARTUP_COUNT = STARTUP_CYCLES
)
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regRdData,
	input wire logic        batteryLow,
	input wire logic        readyPin,
	input wire logic [2:0]  chargeCurrentCode,
	input wire logic        emergencyCharge,
	input wire logic        chargeRun,
	input wire logic        switchedOutputHiZ,
	input wire logic        switchedOutputToBattery,
	input wire ebsc_state_t stateOut,
	input wire logic        prechargeSwitch,
	input wire logic        sw1,
	input wire logic        sw2,
	input wire logic        sw3,
	input wire logic        sw4
);
	timeunit 1ns;
	timeprecision 100ps;
	int suCnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Cycles spent in Startup
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			suCnt <= 0;
		else if (stateOut == ST_STARTUP)
			suCnt <= suCnt + 1;

	a_startup_exit:
	assert property ($past(stateOut) == ST_STARTUP && stateOut != ST_STARTUP
		|-> stateOut == ST_STANDBY && suCnt >= STARTUP_COUNT - 3)
		else $error("startup left early or wrongly");
	a_startup_bound:
	assert property (stateOut == ST_STARTUP |-> suCnt <= STARTUP_COUNT + 3)
		else $error("startup too long");
	a_standby_ready_low:
	assert property (stateOut == ST_STANDBY && $past(stateOut) == ST_STANDBY
		|-> !readyPin)
		else $error("ready high in standby");
	a_ready_mirror:
	assert property (regAddr == ADDR_STATUS |-> regRdData[0] == readyPin)
		else $error("ready bit differs from pin");
	a_emergency_code:
	assert property (emergencyCharge == (chargeCurrentCode == ICH_EMERGENCY))
		else $error("emergency flag wrong");
	a_run_cause:
	assert property (chargeRun
		|-> $past(stateOut) == ST_CHARGE && !$past(batteryLow))
		else $error("charging outside charge or on low battery");
	a_active_output:
	assert property (stateOut == ST_ACTIVE && $past(stateOut) == ST_ACTIVE
		|-> !switchedOutputHiZ && !switchedOutputToBattery)
		else $error("switched output not regulated in active");
	a_switch_pairs:
	assert property (!(sw1 && sw2) && !(sw1 && sw3) && !(sw2 && sw3))
		else $error("illegal switch pair");
	a_standby_exit:
	assert property ($past(stateOut) == ST_STANDBY && stateOut != ST_STANDBY
		|-> stateOut == ST_CHARGE)
		else $error("standby left to wrong state");
	a_precharge_charge:
	assert property (prechargeSwitch
		|-> stateOut == ST_CHARGE || $past(stateOut) == ST_CHARGE)
		else $error("precharge outside charge");
endmodule

bind ebsc_state_control ebsc_state_control_asserts
	#(.STARTUP_COUNT(STARTUP_COUNT)) i_ebsc_state_control_asserts (
	.clk, .rstn, .regAddr, .regRdData, .batteryLow, .readyPin,
	.chargeCurrentCode, .emergencyCharge, .chargeRun, .switchedOutputHiZ,
	.switchedOutputToBattery, .stateOut, .prechargeSwitch,
	.sw1, .sw2, .sw3, .sw4);

// >>> ebsc_host.sv
// Host model: byte register writes and reads toward the controller.
// Assumes clk and rstn shared with the controller; driven on falling edges.
module ebsc_host
	import ebsc_pkg::*;
#(
	parameter int HOLD_OFF = 60
)
(
	input  wire logic       clk,
	input  wire logic       rstn,
	output logic            regWrEn,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	input  wire logic [7:0] regRdData
);
	timeunit 1ns;
	timeprecision 100ps;
	int   waitCnt;
	logic lateGate = 1'b0;

	initial
	begin
		regWrEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end

	// Power-up hold-off before any access
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			waitCnt <= 0;
		else if (waitCnt < HOLD_OFF)
			waitCnt <= waitCnt + 1;

	// Bounded hold-off; running out is flagged for the bench
	task automatic gate();
		int i;
		i = 0;
		while (waitCnt < HOLD_OFF && i <= HOLD_OFF)
		begin
			i++;
			@(negedge clk);
		end
		if (waitCnt < HOLD_OFF)
			lateGate = 1'b1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		gate();
		@(negedge clk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge clk);
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		gate();
		@(negedge clk);
		regAddr = a;
		@(posedge clk);
		d = regRdData;
		@(negedge clk);
	endtask
endmodule

// >>> ebsc_state_control_bench.sv
// Self-checking bench for the state controller with a host model.
// Assumes shortened startup; analog comparators driven directly.
module ebsc_state_control_bench
	import ebsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SU = 50;
	logic clk = 1'b0, rstn = 1'b0, startPin = 1'b0, batteryLow = 1'b0;
	logic outputLow = 1'b0, capBelowOutput = 1'b0, capAbovePrecharge = 1'b0;
	logic regWrEn, chargeRun, readyPin, emergencyCharge, switchedOutputHiZ;
	logic switchedOutputToBattery, alwaysOnFromBattery, prechargeSwitch;
	logic sw1, sw2, sw3, sw4;
	logic [4:0] capLevel = 5'h00, optTarget = 5'h14;
	logic [7:0] regAddr, regWrData, regRdData, rv;
	logic [2:0] chargeCurrentCode, batteryMinCode;
	logic [3:0] outputVoltageCode;
	ebsc_state_t stateOut;
	int err_count = 0, comparisons = 0, n;

	always #2 clk = ~clk;

	ebsc_state_control #(.STARTUP_COUNT(SU)) i_ebsc_state_control (.clk,
		.rstn, .regWrEn, .regAddr, .regWrData, .regRdData, .startPin,
		.capLevel, .capAbovePrecharge, .batteryLow, .outputLow,
		.capBelowOutput, .optTarget, .readyPin, .chargeCurrentCode,
		.emergencyCharge, .batteryMinCode, .outputVoltageCode, .chargeRun,
		.switchedOutputHiZ, .switchedOutputToBattery, .alwaysOnFromBattery,
		.stateOut, .prechargeSwitch, .sw1, .sw2, .sw3, .sw4);
	ebsc_host #(.HOLD_OFF(SU + 8)) i_ebsc_host (.clk, .rstn, .regWrEn,
		.regAddr, .regWrData, .regRdData);

	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_ebsc_host.wr(a, d);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		i_ebsc_host.rd(a, rv);
		chk(rv, e);
	endtask

	// Bounded waits; running out ends the run
	task automatic waitSt(input ebsc_state_t s, input int lim);
		n = 0;
		while (stateOut !== s && n < lim)
		begin
			n++;
			@(negedge clk);
		end
		if (stateOut !== s)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic waitRdy(input int lim);
		n = 0;
		while (readyPin !== 1'b1 && n < lim)
		begin
			n++;
			@(negedge clk);
		end
		if (readyPin !== 1'b1)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask

	// Collects which switches close over more than one period
	task automatic swScan(input logic [4:0] e);
		logic [4:0] acc;
		acc = 5'h00;
		cyc(260);
		repeat (300)
		begin
			@(negedge clk);
			acc = acc | {prechargeSwitch, sw1, sw2, sw3, sw4};
		end
		chk(acc, e);
	endtask

	task automatic tStartup();
		chk({stateOut, readyPin}, {ST_STARTUP, 1'b0});
		waitSt(ST_STANDBY, SU + 10);
		chk(n >= SU - 3 && n <= SU + 3, 1'b1);
		rdChk(ADDR_CEIL, CEIL_RST);
		rdChk(ADDR_CHARGE, CHARGE_RST);
		rdChk(ADDR_WARN, WARN_RST);
		rdChk(ADDR_CMD, CMD_RST);
		rdChk(8'h3f, 8'h00);
		rdChk(ADDR_STATUS, 8'h00);
	endtask

	task automatic tConfig();
		for (int c = 0; c < 5; c++)
		begin
			wr(ADDR_CHARGE, {c[2:0], 5'h15});
			cyc(1);
			chk(chargeCurrentCode, c[2:0]);
			chk(emergencyCharge, c == 4);
		end
		chk({batteryMinCode, switchedOutputHiZ, switchedOutputToBattery},
			5'h16);
		rdChk(ADDR_CHARGE, 8'h95);
		wr(ADDR_STATUS, 8'hff);
		rdChk(ADDR_STATUS, 8'h00);
		wr(ADDR_CHARGE, 8'h05);
		cyc(1);
		chk({switchedOutputHiZ, switchedOutputToBattery}, 2'b01);
	endtask

	task automatic tDemand();
		wr(ADDR_PROFILE, 8'h00);
		wr(ADDR_FIX, 8'hf0);
		wr(ADDR_CEIL, 8'h00);
		capLevel = 5'h0f;
		capAbovePrecharge = 1'b1;
		wr(ADDR_CMD, 8'h01);
		waitSt(ST_CHARGE, 4);
		cyc(3);
		chk(chargeRun, 1'b1);
		swScan(5'h17);
		i_ebsc_host.rd(ADDR_VCAP, rv);
		chk(rv[4:0], 5'h0f);
		batteryLow = 1'b1;
		cyc(3);
		chk(chargeRun, 1'b0);
		cyc(LOWBAT_CYCLES);
		i_ebsc_host.rd(ADDR_STATUS, rv);
		chk(rv[ST_LOWBAT], 1'b1);
		batteryLow = 1'b0;
		cyc(3);
		chk({stateOut, chargeRun}, {ST_CHARGE, 1'b1});
		capLevel = 5'h10;
		waitSt(ST_ACTIVE, 4);
		cyc(2);
		chk({readyPin, alwaysOnFromBattery}, 2'b10);
		swScan(5'h0b);
		capBelowOutput = 1'b1;
		swScan(5'h0d);
		outputLow = 1'b1;
		cyc(3);
		outputLow = 1'b0;
		cyc(3);
		i_ebsc_host.rd(ADDR_STATUS, rv);
		chk({rv[ST_ALARM], readyPin}, 2'b10);
		wr(ADDR_CMD, 8'h00);
		waitSt(ST_STANDBY, 4);
	endtask

	task automatic tForce();
		capLevel = 5'h02;
		capAbovePrecharge = 1'b0;
		wr(ADDR_CMD, 8'h01);
		waitSt(ST_CHARGE, 4);
		swScan(5'h10);
		wr(ADDR_CMD, 8'h05);
		waitSt(ST_ACTIVE, 4);
		wr(ADDR_CMD, 8'h00);
		waitSt(ST_STANDBY, 4);
		wr(ADDR_CMD, 8'h08);
		startPin = 1'b1;
		waitSt(ST_CHARGE, 4);
		startPin = 1'b0;
		waitSt(ST_STANDBY, 4);
	endtask

	task automatic tCont();
		wr(ADDR_PROFILE, 8'h01);
		wr(ADDR_CEIL, 8'h10);
		capLevel = 5'h13;
		capAbovePrecharge = 1'b1;
		wr(ADDR_CMD, 8'h02);
		waitSt(ST_CHARGE, 4);
		cyc(3);
		chk(chargeRun, 1'b1);
		capLevel = 5'h14;
		cyc(4);
		chk({stateOut, chargeRun, readyPin}, {ST_CHARGE, 2'b01});
		capLevel = 5'h13;
		cyc(4);
		chk({stateOut, chargeRun}, {ST_CHARGE, 1'b1});
		capLevel = 5'h14;
		wr(ADDR_CMD, 8'h06);
		waitSt(ST_ACTIVE, 4);
		wr(ADDR_WARN, 8'h84);
		cyc(2);
		chk(outputVoltageCode, 4'h4);
		capLevel = 5'h03;
		cyc(3);
		i_ebsc_host.rd(ADDR_STATUS, rv);
		chk({rv[ST_WARNING], readyPin}, 2'b10);
		waitRdy(WARN_CYCLES + 20);
		chk(n > WARN_CYCLES - 20, 1'b1);
		wr(ADDR_CMD, 8'h02);
		waitSt(ST_CHARGE, 4);
		wr(ADDR_CMD, 8'h00);
		waitSt(ST_STANDBY, 4);
	endtask

	task automatic tReset();
		rdChk(ADDR_CHARGE, 8'h05);
		wr(ADDR_CMD, 8'h02);
		waitSt(ST_CHARGE, 4);
		rstn = 1'b0;
		cyc(2);
		chk({stateOut, readyPin}, {ST_STARTUP, 1'b0});
		rstn = 1'b1;
		waitSt(ST_STANDBY, SU + 10);
		rdChk(ADDR_CMD, 8'h00);
		chk(i_ebsc_host.lateGate, 1'b0);
	endtask

	initial
	begin
		cyc(16);
		rstn = 1'b1;
		tStartup();
		tConfig();
		tDemand();
		tForce();
		tCont();
		tReset();
		tally_and_finish();
	end
endmodule
